/* design/edsc_top.sv */
// external debug status and control registers of one processing element
// assumes a debugger port synchronous to clock and core status inputs
`timescale 1ns/1ps
`default_nettype none
module edsc_top
	import edsc_pkg::*;
#(
	parameter bit HAS_EL2       = 1'b1,
	parameter bit HAS_IMPRECISE = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        rst,
	// debugger register port
	input  wire logic        reg_sel,
	input  wire logic        reg_write,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rvalid,
	// core status
	input  wire logic        core_halted,
	input  wire logic        halt_entry,
	input  wire logic [5:0]  halt_cause,
	input  wire logic [1:0]  cur_level,
	input  wire logic        ext_debug_allowed,
	input  wire logic        ext_hyp_debug_allowed,
	input  wire logic        ext_halt_pending,
	input  wire logic        os_lock,
	input  wire logic        halt_allowed,
	input  wire logic        rx_channel_occupied,
	input  wire logic        tx_channel_occupied,
	input  wire logic        instr_xfer_empty,
	input  wire logic        rx_overrun_evt,
	input  wire logic        tx_underrun_evt,
	input  wire logic        instr_ovr_evt,
	input  wire logic        halted_exc_evt,
	input  wire logic        retire_evt,
	input  wire logic        async_abort_pend,
	input  wire logic        pcs_read_ok,
	input  wire logic        pcs_at_el2,
	input  wire logic        bp_wp_access,
	input  wire logic        halt_event,
	// controls to the core
	output logic             imprecise_entry_request,
	output logic             mask_el1_irq,
	output logic             mask_other_irq,
	output logic             sw_access_event,
	output logic             halt_event_ok,
	output logic             mem_access_mode
);
	logic        wr_status;
	logic        wr_reserve;
	logic        clr_prog;
	logic        clr_err;
	logic        req_imprecise;
	logic [N_FLAG-1:0] flag_set;
	logic [N_FLAG-1:0] flag_clr;
	logic [N_FLAG-1:0] flags;
	logic [31:0] ctx_word;
	logic [31:0] status_word;

	logic [1:0]  irq_mask_field_ff;
	logic        trap_bp_wp_access_ff;
	logic        mem_access_mode_ff;
	logic        halting_enable_ff;
	logic        hyp_halt_disabled_ff;
	logic [5:0]  halt_code_ff;
	logic [1:0]  nxt_irq_mask_field;
	logic        nxt_trap_bp_wp_access;
	logic        nxt_mem_access_mode;
	logic        nxt_halting_enable;
	logic        nxt_hyp_halt_disabled;
	logic [5:0]  nxt_halt_code;
	logic [31:0] rdata_ff;
	logic        rvalid_ff;
	logic [31:0] nxt_rdata;
	logic        nxt_rvalid;
	logic        imprecise_ff;
	logic        nxt_imprecise;
	logic [1:0]  mask_eff;

	// decode; clear bits act only as single-cycle pulses
	always_comb begin
		wr_status     = reg_sel & reg_write & (reg_addr == OFS_STATUS_CTRL);
		wr_reserve    = reg_sel & reg_write & (reg_addr == OFS_RESERVE_CTRL);
		clr_prog      = wr_reserve & reg_wdata[B_CLR_PROG];
		clr_err       = wr_reserve & reg_wdata[B_CLR_ERR];
		req_imprecise = wr_reserve & reg_wdata[B_IMPRECISE] & HAS_IMPRECISE
			& ext_debug_allowed & (~HAS_EL2 | ext_hyp_debug_allowed);
	end

	// debugger owns keeping an external halt request pending first
	always_comb begin
		nxt_imprecise = req_imprecise;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			imprecise_ff <= 1'b0;
		end else begin
			imprecise_ff <= nxt_imprecise;
		end
	end

	assign imprecise_entry_request = imprecise_ff;

	// sticky flags
	always_comb begin
		flag_set         = '0;
		flag_clr         = '0;
		flag_set[F_RX_OVR]    = rx_overrun_evt;
		flag_set[F_TX_UND]    = tx_underrun_evt;
		flag_set[F_INSTR_OVR] = instr_ovr_evt;
		flag_set[F_ERR]  = halted_exc_evt | rx_overrun_evt | tx_underrun_evt
			| instr_ovr_evt;
		flag_set[F_PROG] = retire_evt;
		flag_clr[F_RX_OVR]    = clr_err;
		flag_clr[F_TX_UND]    = clr_err;
		flag_clr[F_ERR]  = clr_err;
		flag_clr[F_INSTR_OVR] = (clr_err & core_halted) | halt_entry;
		flag_clr[F_PROG] = clr_prog;
	end

	edsc_sticky_flags #(
		.N(N_FLAG)
	) u_flags (
		.clock     (clock),
		.rst       (rst),
		.set_pulse (flag_set),
		.clr_pulse (flag_clr),
		.flag      (flags)
	);

	edsc_ctx_sample #(
		.HAS_EL2(HAS_EL2)
	) u_ctx (
		.clock       (clock),
		.rst         (rst),
		.pcs_read_ok (pcs_read_ok),
		.pcs_at_el2  (pcs_at_el2),
		.ctx_word    (ctx_word)
	);

	// control fields; rst is the cold reset, warm resets never reach here
	always_comb begin
		nxt_irq_mask_field    = irq_mask_field_ff;
		nxt_trap_bp_wp_access = trap_bp_wp_access_ff;
		nxt_mem_access_mode   = mem_access_mode_ff;
		nxt_halting_enable    = halting_enable_ff;
		nxt_hyp_halt_disabled = hyp_halt_disabled_ff;
		nxt_halt_code         = halt_code_ff;
		if (wr_status) begin
			nxt_irq_mask_field    = reg_wdata[B_MASK_HI:B_MASK_LO];
			nxt_trap_bp_wp_access = reg_wdata[B_TRAP];
			nxt_mem_access_mode   = reg_wdata[B_MEM_MODE];
			nxt_halting_enable    = reg_wdata[B_HALT_EN];
		end
		if (halt_entry) begin
			nxt_mem_access_mode = 1'b0;
			nxt_halt_code       = halt_cause;
			// hyp mode halts report zero, otherwise the inverted permission
			nxt_hyp_halt_disabled = (cur_level == EL_HYP) ? 1'b0
				: ~ext_hyp_debug_allowed;
		end else if (!core_halted) begin
			nxt_hyp_halt_disabled = ~ext_hyp_debug_allowed;
			nxt_halt_code         = ST_RUNNING;
		end
		if (!HAS_EL2) begin
			nxt_hyp_halt_disabled = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_mask_field_ff    <= MASK_NONE;
			trap_bp_wp_access_ff <= 1'b0;
			mem_access_mode_ff   <= 1'b0;
			halting_enable_ff    <= 1'b0;
			hyp_halt_disabled_ff <= 1'b0;
			halt_code_ff         <= ST_RUNNING;
		end else begin
			irq_mask_field_ff    <= nxt_irq_mask_field;
			trap_bp_wp_access_ff <= nxt_trap_bp_wp_access;
			mem_access_mode_ff   <= nxt_mem_access_mode;
			halting_enable_ff    <= nxt_halting_enable;
			hyp_halt_disabled_ff <= nxt_hyp_halt_disabled;
			halt_code_ff         <= nxt_halt_code;
		end
	end

	// reserved codes act as the full mask, the safer of the defined codes
	always_comb begin
		mask_eff = irq_mask_field_ff;
		if (irq_mask_field_ff == MASK_RSVD || (irq_mask_field_ff == MASK_EL1 && !HAS_EL2)) begin
			mask_eff = MASK_ALL;
		end
	end

	always_comb begin
		mask_el1_irq    = ext_debug_allowed & !core_halted & (mask_eff != MASK_NONE);
		mask_other_irq  = ext_debug_allowed & !core_halted & (mask_eff == MASK_ALL)
			& ext_hyp_debug_allowed;
		sw_access_event = bp_wp_access & trap_bp_wp_access_ff & !os_lock & halt_allowed;
		halt_event_ok   = halt_event & halting_enable_ff;
		mem_access_mode = mem_access_mode_ff & core_halted;
	end

	// status word as read by the debugger
	always_comb begin
		status_word                       = WORD_ZERO;
		status_word[B_RX_OCC]             = rx_channel_occupied;
		status_word[B_TX_OCC]             = tx_channel_occupied;
		status_word[B_INSTR_OVR]          = flags[F_INSTR_OVR];
		status_word[B_RX_OVR]             = flags[F_RX_OVR];
		status_word[B_TX_UND]             = flags[F_TX_UND];
		status_word[B_PROG]               = flags[F_PROG];
		status_word[B_INSTR_EMPTY]        = instr_xfer_empty;
		status_word[B_MASK_HI:B_MASK_LO]  = irq_mask_field_ff;
		status_word[B_TRAP]               = trap_bp_wp_access_ff;
		status_word[B_MEM_MODE]           = mem_access_mode_ff;
		status_word[B_ONE_HI]             = 1'b1;
		status_word[B_ONE_LO]             = 1'b1;
		status_word[B_HYP_DIS]            = hyp_halt_disabled_ff;
		status_word[B_HALT_EN]            = halting_enable_ff;
		status_word[B_EL_HI:B_EL_LO]      = core_halted ? cur_level : EL_ZERO;
		status_word[B_ABORT]              = core_halted & async_abort_pend;
		status_word[B_ERR]                = flags[F_ERR];
		status_word[B_STAT_HI:0]          = halt_code_ff;
	end

	// read path; reserve register is write-only and reads zero
	always_comb begin
		nxt_rvalid = reg_sel & ~reg_write;
		nxt_rdata  = WORD_ZERO;
		if (reg_sel && !reg_write) begin
			unique case (reg_addr)
				OFS_STATUS_CTRL: nxt_rdata = status_word;
				OFS_CTX_SAMPLE:  nxt_rdata = ctx_word;
				default:         nxt_rdata = WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_ff  <= WORD_ZERO;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign reg_rvalid = rvalid_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_imprecise_gate: assert property (imprecise_entry_request |-> $past(ext_debug_allowed))
		else $error("imprecise request without debug permission");
	a_imprecise_set: assert property (req_imprecise |=> imprecise_entry_request)
		else $error("imprecise request not raised");
	a_prog_clear: assert property (clr_prog && !retire_evt |=> !flags[F_PROG])
		else $error("progress flag not cleared");
	a_prog_set: assert property (retire_evt |=> flags[F_PROG])
		else $error("progress flag not set on retire");
	a_err_clear: assert property (clr_err && !rx_overrun_evt && !tx_underrun_evt
		&& !instr_ovr_evt && !halted_exc_evt |=> !flags[F_ERR] && !flags[F_RX_OVR])
		else $error("error flags not cleared");
	a_ito_entry: assert property (halt_entry && !instr_ovr_evt |=> !flags[F_INSTR_OVR])
		else $error("overrun flag kept on halt entry");
	a_err_sticky: assert property (rx_overrun_evt |=> flags[F_ERR] && flags[F_RX_OVR])
		else $error("overrun not recorded");
	a_ma_entry: assert property (halt_entry |=> !mem_access_mode_ff)
		else $error("memory access mode kept on halt entry");
	a_el_running: assert property (!core_halted && reg_sel && !reg_write
		&& reg_addr == OFS_STATUS_CTRL |=> reg_rdata[B_EL_HI:B_EL_LO] == EL_ZERO)
		else $error("level not zero while running");
	// halted clear-error must also drop the instruction overrun flag
	a_ito_halted_clear: assert property (clr_err && core_halted && !instr_ovr_evt
		|=> !flags[F_INSTR_OVR])
		else $error("instruction overrun kept after halted clear");
	a_hdd_running: assert property (!core_halted && !halt_entry && !ext_hyp_debug_allowed
		|=> hyp_halt_disabled_ff == HAS_EL2)
		else $error("hyp disabled bit not tracking while running");
	a_mask_halted: assert property (core_halted |-> !mask_el1_irq && !mask_other_irq)
		else $error("interrupt mask active while halted");
	a_halt_gate: assert property (halt_event_ok |-> halting_enable_ff)
		else $error("halt event passed with halting disabled");
	a_code_entry: assert property (halt_entry |=> halt_code_ff == $past(halt_cause))
		else $error("halt cause not captured on entry");
	a_hdd_frozen: assert property (core_halted && !halt_entry |=> $stable(hyp_halt_disabled_ff))
		else $error("hyp disabled bit moved while halted");
	a_trap_event: assert property (sw_access_event |-> trap_bp_wp_access_ff && !os_lock)
		else $error("software access event without trap");
	a_code_running: assert property (!core_halted && !halt_entry |=> halt_code_ff == ST_RUNNING)
		else $error("status code not running");

	c_imprecise: cover property (ext_halt_pending && req_imprecise ##1 imprecise_entry_request);
	c_clear_err: cover property (flags[F_ERR] ##1 clr_err);
	c_halt_entry: cover property (halt_entry ##1 core_halted);
	c_ctx_read: cover property (pcs_read_ok && pcs_at_el2);
endmodule
`default_nettype wire

/* include/edsc_pkg.sv */
// constants for the external debug status and control block
// assumes one 250 MHz clock and a cold reset on rst
package edsc_pkg;
	localparam logic [11:0] OFS_STATUS_CTRL  = 12'h088;
	localparam logic [11:0] OFS_RESERVE_CTRL = 12'h090;
	localparam logic [11:0] OFS_CTX_SAMPLE   = 12'h0A8;
	// reserve control bits
	localparam int B_IMPRECISE = 4;
	localparam int B_CLR_PROG  = 3;
	localparam int B_CLR_ERR   = 2;
	// status and control bits
	localparam int B_RX_OCC    = 30;
	localparam int B_TX_OCC    = 29;
	localparam int B_INSTR_OVR   = 28;
	localparam int B_RX_OVR      = 27;
	localparam int B_TX_UND      = 26;
	localparam int B_PROG        = 25;
	localparam int B_INSTR_EMPTY = 24;
	localparam int B_MASK_HI     = 23;
	localparam int B_MASK_LO     = 22;
	localparam int B_TRAP        = 21;
	localparam int B_MEM_MODE    = 20;
	localparam int B_ONE_HI      = 18;
	localparam int B_ONE_LO      = 16;
	localparam int B_HYP_DIS     = 15;
	localparam int B_HALT_EN     = 14;
	localparam int B_EL_HI     = 9;
	localparam int B_EL_LO     = 8;
	localparam int B_ABORT     = 7;
	localparam int B_ERR       = 6;
	localparam int B_STAT_HI   = 5;
	localparam int B_CTX_WORLD = 31;
	localparam int B_CTX_EL2   = 30;
	// sticky flag indices
	localparam int F_RX_OVR    = 0;
	localparam int F_TX_UND    = 1;
	localparam int F_ERR       = 2;
	localparam int F_INSTR_OVR = 3;
	localparam int F_PROG = 4;
	localparam int N_FLAG = 5;
	// interrupt mask codes
	localparam logic [1:0] MASK_NONE = 2'h0;
	localparam logic [1:0] MASK_EL1  = 2'h1;
	localparam logic [1:0] MASK_RSVD = 2'h2;
	localparam logic [1:0] MASK_ALL  = 2'h3;
	// halt status codes
	localparam logic [5:0] ST_RUNNING  = 6'h02;
	localparam logic [5:0] ST_EXT_REQ  = 6'h13;
	localparam logic [5:0] ST_WATCHPT  = 6'h2B;
	localparam logic [1:0] EL_ZERO     = 2'h0;
	localparam logic [1:0] EL_HYP      = 2'h2;
	localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
endpackage

/* design/edsc_sticky_flags.sv */
// sticky flag bank: per bit set and clear pulses
// assumes set and clear arrive as single-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module edsc_sticky_flags
	import edsc_pkg::*;
#(
	parameter int N = N_FLAG
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [N-1:0] set_pulse,
	input  wire logic [N-1:0] clr_pulse,
	output logic      [N-1:0] flag
);
	logic [N-1:0] flag_ff;
	logic [N-1:0] nxt_flag;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_flag
			// set beats clear so an event in the clearing cycle survives
			always_comb begin
				nxt_flag[gi] = set_pulse[gi] | (flag_ff[gi] & ~clr_pulse[gi]);
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;
endmodule
`default_nettype wire

/* design/edsc_ctx_sample.sv */
// context sample register, loaded by good pc sample reads
// assumes the core gives the level-two context with the read strobe
`timescale 1ns/1ps
`default_nettype none
module edsc_ctx_sample
	import edsc_pkg::*;
#(
	parameter bit HAS_EL2 = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        pcs_read_ok,
	input  wire logic        pcs_at_el2,
	output logic      [31:0] ctx_word
);
	logic el2_ff;
	logic nxt_el2;

	always_comb begin
		nxt_el2 = el2_ff;
		if (pcs_read_ok) begin
			nxt_el2 = pcs_at_el2 & HAS_EL2;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			el2_ff <= 1'b0;
		end else begin
			el2_ff <= nxt_el2;
		end
	end

	always_comb begin
		ctx_word              = WORD_ZERO;
		ctx_word[B_CTX_WORLD] = 1'b1;
		ctx_word[B_CTX_EL2]   = el2_ff & HAS_EL2;
	end
endmodule
`default_nettype wire

/* testbench/edsc_dbg_model.sv */
// debugger model: turns bench requests into one-cycle register accesses
// assumes requests arrive from the bench just after rising edges
`timescale 1ns/1ps
`default_nettype none
module edsc_dbg_model
	import edsc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        req_go,
	input  wire logic        req_write,
	input  wire logic [11:0] req_addr,
	input  wire logic [31:0] req_wdata,
	input  wire logic        ext_halt_pending,
	output logic             reg_sel,
	output logic             reg_write,
	output logic      [11:0] reg_addr,
	output logic      [31:0] reg_wdata
);
	logic        sel_ff;
	logic        wr_ff;
	logic [11:0] addr_ff;
	logic [31:0] data_ff;
	logic        nxt_sel;
	logic        nxt_wr;
	logic [11:0] nxt_addr;
	logic [31:0] nxt_data;

	// idle lines flip each cycle so a stale value never passes for a request
	always_comb begin
		nxt_sel  = req_go;
		nxt_wr   = req_go ? req_write : ~wr_ff;
		nxt_addr = req_go ? req_addr : ~addr_ff;
		nxt_data = req_go ? req_wdata : ~data_ff;
		if (req_go && req_write && req_addr == OFS_RESERVE_CTRL && !ext_halt_pending)
			nxt_data[B_IMPRECISE] = 1'b0;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sel_ff  <= 1'b0;
			wr_ff   <= 1'b0;
			addr_ff <= 12'h000;
			data_ff <= 32'h0000_0000;
		end else begin
			sel_ff  <= nxt_sel;
			wr_ff   <= nxt_wr;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
		end
	end

	assign reg_sel   = sel_ff;
	assign reg_write = wr_ff;
	assign reg_addr  = addr_ff;
	assign reg_wdata = data_ff;
endmodule
`default_nettype wire

/* testbench/edsc_top_test.sv */
// self-checking bench for the debug status and control registers
// assumes the debugger model drives the register port
`timescale 1ns/1ps
`default_nettype none
module edsc_top_test
	import edsc_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        req_go = 1'b0;
	logic        req_write = 1'b0;
	logic [11:0] req_addr = 12'h000;
	logic [31:0] req_wdata = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_A6E5;
	logic        reg_sel, reg_write, reg_rvalid, imprecise_entry_request;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        mask_el1_irq, mask_other_irq, sw_access_event, halt_event_ok, mem_access_mode;
	logic        core_halted = 1'b0, rx_channel_occupied = 1'b0;
	logic        tx_channel_occupied = 1'b0, instr_xfer_empty = 1'b0;
	logic        async_abort_pend = 1'b0, pcs_at_el2 = 1'b0;
	logic        ext_debug_allowed = 1'b1, ext_hyp_debug_allowed = 1'b1;
	logic        ext_halt_pending = 1'b0, os_lock = 1'b0, halt_allowed = 1'b1;
	logic        bp_wp_access = 1'b0, halt_event = 1'b0;
	logic [1:0]  cur_level = 2'h0;
	logic [5:0]  halt_cause = 6'h00;
	logic [6:0]  evt = 7'h00;
	logic [31:0] q[$];
	int          errors = 0;
	int          checked = 0;
	int          imp_cnt = 0;

	always #2 clock = ~clock;

	edsc_dbg_model i_edsc_dbg_model (.clock, .rst, .req_go, .req_write, .req_addr,
		.req_wdata, .ext_halt_pending, .reg_sel, .reg_write, .reg_addr, .reg_wdata);

	edsc_top i_edsc_top (.clock, .rst, .reg_sel, .reg_write, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .core_halted, .halt_entry(evt[5]), .halt_cause,
		.cur_level, .ext_debug_allowed, .ext_hyp_debug_allowed, .ext_halt_pending,
		.os_lock, .halt_allowed, .rx_channel_occupied, .tx_channel_occupied,
		.instr_xfer_empty, .rx_overrun_evt(evt[0]), .tx_underrun_evt(evt[1]),
		.instr_ovr_evt(evt[2]), .halted_exc_evt(evt[3]), .retire_evt(evt[4]),
		.async_abort_pend, .pcs_read_ok(evt[6]), .pcs_at_el2, .bp_wp_access,
		.halt_event, .imprecise_entry_request, .mask_el1_irq, .mask_other_irq,
		.sw_access_event, .halt_event_ok, .mem_access_mode);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		req_go    <= 1'b1;
		req_write <= w;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge clock);
		req_go <= 1'b0;
		repeat (3) @(posedge clock);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		op(1'b0, a, 32'h0000_0000);
	endtask

	task automatic pulse(input logic [6:0] v);
		@(posedge clock);
		evt <= v;
		@(posedge clock);
		evt <= 7'h00;
		repeat (2) @(posedge clock);
	endtask

	// order: halt_event_ok, sw_access_event, mask_el1, mask_other, mem_access_mode
	task automatic cmb(input logic [4:0] e);
		@(posedge clock);
		#1;
		chk("core controls", 32'(e), 32'({halt_event_ok, sw_access_event, mask_el1_irq,
			mask_other_irq, mem_access_mode}));
	endtask

	task automatic test_done();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// read results are matched in order against the noted expectations
	always @(posedge clock) begin
		if (imprecise_entry_request === 1'b1)
			imp_cnt++;
		if (reg_rvalid === 1'b1) begin
			if (q.size() == 0) begin
				errors++;
				$display("Error read expected none seen %h", reg_rdata);
			end else
				chk("read data", q.pop_front(), reg_rdata);
		end
	end

	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(OFS_STATUS_CTRL, 32'h0005_0002);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			op(1'b1, OFS_STATUS_CTRL, seed);
			rd(OFS_STATUS_CTRL, (seed & 32'h00F0_4000) | 32'h0005_0002);
		end
		rx_channel_occupied <= 1'b1;
		tx_channel_occupied <= 1'b1;
		op(1'b1, OFS_STATUS_CTRL, 32'h00F0_4000);
		rd(OFS_STATUS_CTRL, 32'h60F5_4002);
		op(1'b1, 12'h100, 32'hFFFF_FFFF);
		rd(12'h100, 32'h0000_0000);
		rd(OFS_RESERVE_CTRL, 32'h0000_0000);
		halt_event   <= 1'b1;
		bp_wp_access <= 1'b1;
		cmb(5'h1E);
		os_lock               <= 1'b1;
		ext_hyp_debug_allowed <= 1'b0;
		cmb(5'h14);
		os_lock               <= 1'b0;
		ext_hyp_debug_allowed <= 1'b1;
		op(1'b1, OFS_STATUS_CTRL, 32'h0080_0000);
		cmb(5'h06);
		op(1'b1, OFS_STATUS_CTRL, 32'h00F0_4000);
		cmb(5'h1E);
		pulse(7'h13);
		rd(OFS_STATUS_CTRL, 32'h6EF5_4042);
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0008);
		rd(OFS_STATUS_CTRL, 32'h6CF5_4042);
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0004);
		rd(OFS_STATUS_CTRL, 32'h60F5_4002);
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0010);
		ext_halt_pending <= 1'b1;
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0010);
		ext_debug_allowed <= 1'b0;
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0010);
		ext_debug_allowed     <= 1'b1;
		ext_hyp_debug_allowed <= 1'b0;
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0010);
		chk("imprecise pulses", 32'h0000_0001, 32'(imp_cnt));
		cur_level        <= 2'h1;
		halt_cause       <= ST_WATCHPT;
		async_abort_pend <= 1'b1;
		instr_xfer_empty <= 1'b1;
		core_halted      <= 1'b1;
		pulse(7'h20);
		ext_hyp_debug_allowed <= 1'b1;
		pulse(7'h04);
		rd(OFS_STATUS_CTRL, 32'h71E5_C1EB);
		op(1'b1, OFS_STATUS_CTRL, 32'h00F0_4000);
		cmb(5'h19);
		op(1'b1, OFS_RESERVE_CTRL, 32'h0000_0004);
		rd(OFS_STATUS_CTRL, 32'h61F5_C1AB);
		pulse(7'h08);
		rd(OFS_STATUS_CTRL, 32'h61F5_C1EB);
		pcs_at_el2 <= 1'b1;
		pulse(7'h40);
		rd(OFS_CTX_SAMPLE, 32'hC000_0000);
		pcs_at_el2 <= 1'b0;
		pulse(7'h40);
		rd(OFS_CTX_SAMPLE, 32'h8000_0000);
		core_halted      <= 1'b0;
		instr_xfer_empty <= 1'b0;
		async_abort_pend <= 1'b0;
		rd(OFS_STATUS_CTRL, 32'h60F5_4042);
		for (int k = 0; k < 50 && q.size() != 0; k++)
			@(posedge clock);
		if (q.size() != 0) begin
			errors++;
			$display("Error pending reads expected 0 seen %0d", q.size());
		end
		test_done();
	end
endmodule
`default_nettype wire
